//--- bench/indexed_stack_instruction_ext_tb.sv
`timescale 1ns/1ps
module indexed_stack_instruction_ext_tb;
  // ************************************************************
  // Clock, stimulus and counters
  // ************************************************************
  logic mclk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic ext_set_enable = 1'b1;
  ext_decode_pkg::instr_s instr = '0;
  ext_decode_pkg::operand_s operand = '0;
  ext_decode_pkg::fsr_load_s fsr_load = '0;
  logic [7:0] mem_rd_data = 8'h33;
  logic [20:0] ret_top = 21'h00000;
  ext_decode_pkg::mem_s mem;
  ext_decode_pkg::resolve_s res;
  logic [2:0][11:0] file_select_pointer;
  logic pc_load;
  logic busy;
  logic move_drop;
  logic ext_active;
  logic [20:0] pc_value;
  int n_errors = 0;
  int comparisons = 0;

  initial begin
    forever #2 mclk_in = ~mclk_in;
  end

  indexed_stack_instruction_ext i_indexed_stack_instruction_ext (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .ext_set_enable_in(ext_set_enable),
    .instr_in(instr),
    .operand_in(operand),
    .fsr_load_in(fsr_load),
    .mem_rd_data_in(mem_rd_data),
    .ret_top_in(ret_top),
    .mem_out(mem),
    .resolved_out(res),
    .fsr_out(file_select_pointer),
    .pc_load_out(pc_load),
    .pc_value_out(pc_value),
    .busy_out(busy),
    .move_drop_out(move_drop),
    .ext_active_out(ext_active)
  );

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic chk(input logic [20:0] got, input logic [20:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic end_sim;
    $display("Counts: %0d comparisons, %0d errors", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim

  // Checks land 1 ns after the taking edge so registered outputs settle
  task automatic issue(input logic [15:0] w);
    @(posedge mclk_in);
    instr <= '{valid: 1'b1, word: w};
    @(posedge mclk_in);
    instr.valid <= 1'b0;
    #1;
  endtask : issue

  task automatic load(input logic [1:0] s, input logic [11:0] v);
    @(posedge mclk_in);
    fsr_load <= '{valid: 1'b1, sel: s, value: v};
    @(posedge mclk_in);
    fsr_load.valid <= 1'b0;
    #1;
  endtask : load

  task automatic map(input logic a, input logic [7:0] f, input logic ix, input logic [11:0] e);
    @(posedge mclk_in);
    operand <= '{valid: 1'b1, access_sel: a, bank: 4'h3, file_addr: f};
    @(posedge mclk_in);
    operand.valid <= 1'b0;
    #1;
    chk(res.valid, 1'b1);
    chk(res.indexed, ix);
    chk(res.addr, e);
  endtask : map

  // Enable passes a synchroniser, so allow a bounded settling span
  task automatic wait_ext(input logic v);
    for (int i = 0; i < 20 && ext_active !== v; i++) @(posedge mclk_in);
    #1;
    chk(ext_active, v);
  endtask : wait_ext

  task automatic move(input logic [11:0] fp, input logic [6:0] zs, input logic [6:0] zd,
                      input logic wr, input logic [7:0] d);
    load(2'h2, fp);
    issue({9'h1d7, zs});
    chk(mem.rd_en, 1'b1);
    chk(mem.rd_addr, 12'(fp + {5'h00, zs}));
    issue({4'hf, 5'h15, zd});
    chk(mem.wr_en, wr);
    chk(move_drop, !wr);
    if (wr) begin
      chk(mem.wr_addr, 12'(fp + {5'h00, zd}));
      chk(mem.wr_data, d);
    end
  endtask : move

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_push;
    load(2'h2, 12'h1ec);
    issue(16'hea08);
    chk(mem.wr_en, 1'b1);
    chk(mem.wr_addr, 12'h1ec);
    chk(mem.wr_data, 8'h08);
    chk(file_select_pointer[2], 12'h1eb);
    load(2'h2, 12'h000);
    issue(16'hea5a);
    chk(mem.wr_addr, 12'h000);
    chk(file_select_pointer[2], 12'hfff);
    $display("push test finished");
  endtask : t_push

  task automatic t_sub;
    for (int s = 0; s < 3; s++) begin
      load(s[1:0], 12'h3ff);
      issue({8'he9, s[1:0], 6'h23});
      chk(file_select_pointer[s], 12'h3dc);
    end
    load(2'h0, 12'h005);
    issue(16'he93f);
    chk(file_select_pointer[0], 12'hfc6);
    $display("subtract test finished");
  endtask : t_sub

  task automatic t_ret;
    load(2'h2, 12'h3ff);
    @(posedge mclk_in);
    instr <= '{valid: 1'b1, word: 16'he9e3};
    ret_top <= 21'h1abcd;
    // A push offered in the no-op cycle must be dropped
    @(posedge mclk_in);
    instr <= '{valid: 1'b1, word: 16'hea77};
    #1;
    chk(pc_load, 1'b1);
    chk(pc_value, 21'h1abcd);
    chk(file_select_pointer[2], 12'h3dc);
    chk(busy, 1'b1);
    @(posedge mclk_in);
    instr.valid <= 1'b0;
    #1;
    chk(busy, 1'b0);
    chk(pc_load, 1'b0);
    chk(mem.wr_en, 1'b0);
    chk(file_select_pointer[2], 12'h3dc);
    $display("return test finished");
  endtask : t_ret

  task automatic t_move;
    move(12'h080, 7'h05, 7'h06, 1'b1, 8'h33);
    move(12'hffe, 7'h05, 7'h10, 1'b1, 8'h33);
    move(12'hf80, 7'h5b, 7'h10, 1'b1, 8'h00);
    move(12'hf80, 7'h05, 7'h63, 1'b0, 8'h00);
    move(12'hf80, 7'h05, 7'h7f, 1'b0, 8'h00);
    move(12'hf80, 7'h05, 7'h79, 1'b0, 8'h00);
    $display("move test finished");
  endtask : t_move

  // Second word right behind the first, in the read cycle itself
  task automatic t_move_fast;
    load(2'h2, 12'hf80);
    for (int i = 0; i < 2; i++) begin
      @(posedge mclk_in);
      instr <= '{valid: 1'b1, word: (i == 0) ? 16'heb85 : 16'hebdb};
      @(posedge mclk_in);
      instr <= '{valid: 1'b1, word: 16'hf012};
      @(posedge mclk_in);
      instr.valid <= 1'b0;
      #1;
      chk(mem.wr_en, 1'b1);
      chk(mem.wr_addr, 12'hf92);
      chk(mem.wr_data, (i == 0) ? 8'h33 : 8'h00);
    end
    $display("fast move test finished");
  endtask : t_move_fast

  task automatic t_map;
    load(2'h2, 12'ha00);
    map(1'b0, 8'h20, 1'b1, 12'ha20);
    map(1'b0, 8'h5f, 1'b1, 12'ha5f);
    map(1'b0, 8'h60, 1'b0, 12'hf60);
    map(1'b1, 8'h20, 1'b0, 12'h320);
    load(2'h2, 12'h000);
    map(1'b0, 8'h20, 1'b1, 12'h020);
    $display("operand test finished");
  endtask : t_map

  task automatic t_off;
    @(posedge mclk_in);
    ext_set_enable <= 1'b0;
    wait_ext(1'b0);
    load(2'h2, 12'h100);
    issue(16'hea08);
    chk(mem.wr_en, 1'b0);
    chk(file_select_pointer[2], 12'h100);
    map(1'b0, 8'h20, 1'b0, 12'h020);
    @(posedge mclk_in);
    ext_set_enable <= 1'b1;
    wait_ext(1'b1);
    $display("disable test finished");
  endtask : t_off

  // ************************************************************
  // Main sequence and watchdog
  // ************************************************************
  initial begin
    repeat (5) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    wait_ext(1'b1);
    t_push();
    t_sub();
    t_ret();
    t_move();
    t_move_fast();
    t_map();
    t_off();
    end_sim();
  end

  // Whole run needs about 120 cycles; this leaves ample margin
  initial begin
    repeat (3000) @(posedge mclk_in);
    n_errors++;
    end_sim();
  end
endmodule : indexed_stack_instruction_ext_tb

//--- verilog/ext_decode_pkg.sv
package ext_decode_pkg;

  // ************************************************************
  // Opcode fields
  // ************************************************************
  localparam logic [8:0] OP_MOVE_FIRST = 9'h1d7;
  localparam logic [3:0] OP_MOVE_SECOND = 4'hf;
  localparam logic [7:0] OP_PUSH = 8'hea;
  localparam logic [7:0] OP_SUB = 8'he9;
  localparam logic [1:0] SEL_RETURN = 2'h3;
  localparam logic [7:0] IDX_LIMIT = 8'h5f;
  localparam int FP_TWO = 2;

  // ************************************************************
  // Reset values and timing
  // ************************************************************
  localparam logic [11:0] FSR_RST = 12'h000;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int MOVE_CYCLES = 2;
  localparam int RET_CYCLES = 2;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_MOVE_CAP, ST_MOVE_DST, ST_RET_NOP} step_e;

  typedef struct packed {
    logic valid;
    logic [15:0] word;
  } instr_s;

  typedef struct packed {
    logic valid;
    logic access_sel;
    logic [3:0] bank;
    logic [7:0] file_addr;
  } operand_s;

  typedef struct packed {
    logic valid;
    logic indexed;
    logic [11:0] addr;
  } resolve_s;

  typedef struct packed {
    logic valid;
    logic [1:0] sel;
    logic [11:0] value;
  } fsr_load_s;

  typedef struct packed {
    logic rd_en;
    logic [11:0] rd_addr;
    logic wr_en;
    logic [11:0] wr_addr;
    logic [7:0] wr_data;
  } mem_s;

  typedef struct packed {
    step_e st;
    logic [2:0][11:0] file_select_pointer;
    logic [2:0] ext_sync;
    logic ext_on;
    mem_s mem;
    logic pc_load;
    logic [20:0] pc_val;
    logic [7:0] data;
    logic src_ind;
    logic busy;
    logic move_nop;
    resolve_s res;
  } core_s;

  localparam core_s CORE_RST = '0;

endpackage : ext_decode_pkg

//--- verilog/indexed_stack_instruction_ext.sv
`timescale 1ns/1ps
module indexed_stack_instruction_ext #(
  parameter logic [2:0][11:0] IND_BASES = {12'hfdb, 12'hfe3, 12'hfeb},
  parameter int IND_SPAN = 5,
  parameter logic [3:0][11:0] PROT_ADDRS = {12'hff9, 12'hfff, 12'hffe, 12'hffd},
  parameter logic [3:0] ACC_HI_BANK = 4'hf
) (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic ext_set_enable_in,
  input wire ext_decode_pkg::instr_s instr_in,
  input wire ext_decode_pkg::operand_s operand_in,
  input wire ext_decode_pkg::fsr_load_s fsr_load_in,
  input wire logic [7:0] mem_rd_data_in,
  input wire logic [20:0] ret_top_in,
  output ext_decode_pkg::mem_s mem_out,
  output ext_decode_pkg::resolve_s resolved_out,
  output logic [2:0][11:0] fsr_out,
  output logic pc_load_out,
  output logic [20:0] pc_value_out,
  output logic busy_out,
  output logic move_drop_out,
  output logic ext_active_out
);

  // ************************************************************
  // Parameter checks
  // ************************************************************
  if (IND_SPAN < 1 || IND_SPAN > 16) begin : g_bad_span
    $error("IND_SPAN out of range");
  end

  // ************************************************************
  // Address classes
  // ************************************************************
  function automatic logic is_ind(input logic [11:0] a);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 3; i++) begin
      if (a >= IND_BASES[i] && a < IND_BASES[i] + 12'(IND_SPAN)) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction : is_ind

  function automatic logic is_prot(input logic [11:0] a);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (a == PROT_ADDRS[i]) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction : is_prot

  // ************************************************************
  // State
  // ************************************************************
  ext_decode_pkg::core_s q;
  ext_decode_pkg::core_s d;
  logic [15:0] w;
  logic [11:0] fp2;
  logic [11:0] src;
  logic [11:0] dst;
  logic [7:0] mv_val;
  logic [1:0] sel;

  assign w = instr_in.word;
  assign fp2 = q.file_select_pointer[ext_decode_pkg::FP_TWO];
  assign src = fp2 + {5'h00, w[6:0]};
  assign dst = fp2 + {5'h00, w[6:0]};
  assign sel = w[7:6];
  assign mv_val = (q.st == ext_decode_pkg::ST_MOVE_CAP) ?
                  (q.src_ind ? 8'h00 : mem_rd_data_in) : q.data;

  always_comb begin
    d = q;
    // ext_on follows only once the third stage agrees with the second
    d.ext_sync = {q.ext_sync[1:0], ext_set_enable_in};
    if (q.ext_sync[2] == q.ext_sync[1]) begin
      d.ext_on = q.ext_sync[2];
    end
    d.mem.rd_en = 1'b0;
    d.mem.wr_en = 1'b0;
    d.pc_load = 1'b0;
    d.busy = 1'b0;
    d.move_nop = 1'b0;
    d.res.valid = 1'b0;
    if (fsr_load_in.valid && fsr_load_in.sel != ext_decode_pkg::SEL_RETURN) begin
      d.file_select_pointer[fsr_load_in.sel] = fsr_load_in.value;
    end
    // Operand mapping for all byte and bit forms
    if (operand_in.valid) begin
      d.res.valid = 1'b1;
      d.res.indexed = 1'b0;
      if (operand_in.access_sel) begin
        d.res.addr = {operand_in.bank, operand_in.file_addr};
      end else if (q.ext_on && operand_in.file_addr <= ext_decode_pkg::IDX_LIMIT) begin
        d.res.indexed = 1'b1;
        d.res.addr = fp2 + {4'h0, operand_in.file_addr};
      end else if (operand_in.file_addr <= ext_decode_pkg::IDX_LIMIT) begin
        d.res.addr = {4'h0, operand_in.file_addr};
      end else begin
        d.res.addr = {ACC_HI_BANK, operand_in.file_addr};
      end
    end
    case (q.st)
      ext_decode_pkg::ST_IDLE: begin
        // New opcodes exist only with the extension on
        if (instr_in.valid && q.ext_on) begin
          if (w[15:7] == ext_decode_pkg::OP_MOVE_FIRST) begin
            d.mem.rd_en = 1'b1;
            d.mem.rd_addr = src;
            d.src_ind = is_ind(src);
            d.st = ext_decode_pkg::ST_MOVE_CAP;
          end else if (w[15:8] == ext_decode_pkg::OP_PUSH) begin
            d.mem.wr_en = 1'b1;
            d.mem.wr_addr = fp2;
            d.mem.wr_data = w[7:0];
            d.file_select_pointer[ext_decode_pkg::FP_TWO] = fp2 - 12'h001;
          end else if (w[15:8] == ext_decode_pkg::OP_SUB) begin
            if (sel == ext_decode_pkg::SEL_RETURN) begin
              d.file_select_pointer[ext_decode_pkg::FP_TWO] = fp2 - {6'h00, w[5:0]};
              d.pc_load = 1'b1;
              d.pc_val = ret_top_in;
              d.busy = 1'b1;
              d.st = ext_decode_pkg::ST_RET_NOP;
            end else begin
              d.file_select_pointer[sel] = q.file_select_pointer[sel] - {6'h00, w[5:0]};
            end
          end
        end
      end
      ext_decode_pkg::ST_MOVE_CAP, ext_decode_pkg::ST_MOVE_DST: begin
        // Hold the source byte in case the second word is late
        d.data = mv_val;
        d.st = ext_decode_pkg::ST_MOVE_DST;
        if (instr_in.valid && w[15:12] == ext_decode_pkg::OP_MOVE_SECOND) begin
          if (is_ind(dst) || is_prot(dst)) begin
            d.move_nop = 1'b1;
          end else begin
            d.mem.wr_en = 1'b1;
            d.mem.wr_addr = dst;
            d.mem.wr_data = mv_val;
          end
          d.st = ext_decode_pkg::ST_IDLE;
        end
      end
      ext_decode_pkg::ST_RET_NOP: begin
        // Fetched word is discarded while the target is fetched
        d.st = ext_decode_pkg::ST_IDLE;
      end
      default: begin
        d.st = ext_decode_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      q <= ext_decode_pkg::CORE_RST;
    end else begin
      q <= d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign mem_out = q.mem;
  assign resolved_out = q.res;
  assign fsr_out = q.file_select_pointer;
  assign pc_load_out = q.pc_load;
  assign pc_value_out = q.pc_val;
  assign busy_out = q.busy;
  assign move_drop_out = q.move_nop;
  assign ext_active_out = q.ext_on;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);

  logic idle_go;
  logic no_load;
  assign idle_go = instr_in.valid && q.ext_on && q.st == ext_decode_pkg::ST_IDLE;
  assign no_load = !fsr_load_in.valid;

  sequence seq_ret_issue;
    idle_go && w[15:8] == ext_decode_pkg::OP_SUB && sel == ext_decode_pkg::SEL_RETURN;
  endsequence

  sequence seq_ret_nop;
    pc_load_out && busy_out ##1 !pc_load_out && !busy_out && !mem_out.wr_en;
  endsequence

  a_push_store: assert property (
    idle_go && w[15:8] == ext_decode_pkg::OP_PUSH |=>
    mem_out.wr_en && mem_out.wr_addr == $past(fp2) && mem_out.wr_data == $past(w[7:0]))
    else $error("push store wrong");

  a_push_decrement: assert property (
    idle_go && no_load && w[15:8] == ext_decode_pkg::OP_PUSH |=>
    fsr_out[2] == $past(fp2) - 12'h001)
    else $error("push decrement wrong");

  a_sub_pointer: assert property (
    idle_go && no_load && w[15:8] == ext_decode_pkg::OP_SUB && sel == 2'h1 |=>
    fsr_out[1] == $past(q.file_select_pointer[1]) - {6'h00, $past(w[5:0])} && !pc_load_out)
    else $error("pointer subtract wrong");

  a_ret_two_cycles: assert property (
    seq_ret_issue |=> seq_ret_nop)
    else $error("return sequence wrong");

  a_ret_target: assert property (
    seq_ret_issue |=> pc_value_out == $past(ret_top_in) &&
    fsr_out[2] == $past(fp2) - {6'h00, $past(w[5:0])})
    else $error("return target wrong");

  a_move_read: assert property (
    idle_go && w[15:7] == ext_decode_pkg::OP_MOVE_FIRST |=>
    mem_out.rd_en && mem_out.rd_addr == $past(src) ##1 !mem_out.rd_en)
    else $error("move source read wrong");

  a_move_src_zero: assert property (
    q.st == ext_decode_pkg::ST_MOVE_CAP && q.src_ind && instr_in.valid &&
    w[15:12] == ext_decode_pkg::OP_MOVE_SECOND |=>
    !mem_out.wr_en || mem_out.wr_data == 8'h00)
    else $error("indirect source not zero");

  a_move_dst_guard: assert property (
    (q.st == ext_decode_pkg::ST_MOVE_CAP || q.st == ext_decode_pkg::ST_MOVE_DST) &&
    instr_in.valid && w[15:12] == ext_decode_pkg::OP_MOVE_SECOND &&
    (is_ind(dst) || is_prot(dst)) |=> !mem_out.wr_en && move_drop_out)
    else $error("guarded destination written");

  a_ext_off_quiet: assert property (
    instr_in.valid && !q.ext_on && q.st == ext_decode_pkg::ST_IDLE |=>
    !mem_out.wr_en && !mem_out.rd_en && !pc_load_out)
    else $error("extended opcode ran while off");

  a_idx_resolve: assert property (
    operand_in.valid && q.ext_on && !operand_in.access_sel &&
    operand_in.file_addr <= ext_decode_pkg::IDX_LIMIT |=>
    resolved_out.indexed && resolved_out.addr == $past(fp2) + {4'h0, $past(operand_in.file_addr)})
    else $error("indexed operand wrong");

  a_zero_remap: assert property (
    operand_in.valid && fp2 == 12'h000 && !operand_in.access_sel &&
    operand_in.file_addr <= ext_decode_pkg::IDX_LIMIT |=>
    resolved_out.addr == {4'h0, $past(operand_in.file_addr)})
    else $error("zero pointer remap wrong");

  a_bank_literal: assert property (
    operand_in.valid && operand_in.access_sel |=>
    !resolved_out.indexed &&
    resolved_out.addr == {$past(operand_in.bank), $past(operand_in.file_addr)})
    else $error("banked operand wrong");

  a_access_low: assert property (
    operand_in.valid && !q.ext_on && !operand_in.access_sel |=>
    !resolved_out.indexed && resolved_out.addr[7:0] == $past(operand_in.file_addr))
    else $error("plain access operand wrong");

  a_move_dst_write: assert property (
    (q.st == ext_decode_pkg::ST_MOVE_CAP || q.st == ext_decode_pkg::ST_MOVE_DST) &&
    instr_in.valid && w[15:12] == ext_decode_pkg::OP_MOVE_SECOND &&
    !is_ind(dst) && !is_prot(dst) |=>
    mem_out.wr_en && !move_drop_out &&
    mem_out.wr_addr == $past(fp2) + {5'h00, $past(w[6:0])})
    else $error("move destination write wrong");

  a_sub_zero: assert property (
    idle_go && no_load && w[15:8] == ext_decode_pkg::OP_SUB && sel == 2'h0 |=>
    fsr_out[0] == $past(q.file_select_pointer[0]) - {6'h00, $past(w[5:0])} && !pc_load_out)
    else $error("pointer zero subtract wrong");

  // Enable follows only once the last two stages agree
  a_ext_follow: assert property (
    q.ext_sync[2] == q.ext_sync[1] |=> ext_active_out == $past(q.ext_sync[2]))
    else $error("extension enable not followed");

  a_ext_hold: assert property (
    q.ext_sync[2] != q.ext_sync[1] |=> $stable(ext_active_out))
    else $error("extension enable changed early");

endmodule : indexed_stack_instruction_ext
